//--- src/pbc_control.sv
// Functional notes
// - isolate tri-states all pins but management set
// - isolate reset value from bootstrap strap
// - link reset bit resets tx/rx
// - duplex bit reads 0, writes ignored
// - collision test bit is read/write, default 0
// - both speed bits read 0, writes ignored
// - unidirectional and bits 4:0 read 0
// - self-clearing bits clear when action completes
// - soft reset restores defaults, keeps strap
// - link control enables tx and rx
// - loopback returns mii tx to rx, line off
`timescale 1ns/1ps
`default_nettype none
module pbc_control (
  input  wire logic                 clk_i,
  input  wire logic                 reset_n_i,
  input  wire logic                 strap_isolate_i,
  input  wire pbc_pkg::pbc_mgmt_req_t mgmt_i,
  output logic [15:0]               mgmt_rdata_o,
  input  wire pbc_pkg::pbc_mii_tx_t mac_tx_i,
  input  wire pbc_pkg::pbc_mii_rx_t line_rx_i,
  output pbc_pkg::pbc_mii_rx_t      mac_rx_o,
  output logic                      mac_rx_oe_n_o,
  output pbc_pkg::pbc_mii_tx_t      line_tx_o,
  output logic                      line_oe_n_o,
  output logic                      phy_reset_o,
  output logic                      soft_reset_o
);

  logic        strap_s1_q, strap_s2_q, strap_s3_q;
  logic        strap_seen_q;
  logic        isolate_q;
  logic        loopback_q;
  logic        link_ctrl_q;
  logic        col_test_q;
  logic        link_rst_q;
  logic        soft_rst_q;
  logic [3:0]  link_cnt_q;
  logic [3:0]  soft_cnt_q;
  logic [1:0]  strap_fill_q;
  logic        strap_val_q;
  logic        wr_ctrl;
  logic        soft_done;
  logic        soft_start;
  logic        strap_ready;
  logic [15:0] live_bits;
  wire  [15:0] rd_bits;

  assign wr_ctrl     = mgmt_i.req && mgmt_i.wr && (mgmt_i.addr == pbc_pkg::CTRL_ADDR);
  assign soft_done   = soft_rst_q && (soft_cnt_q == 4'h0);
  // the write that starts a soft reset already restores defaults on its own edge
  assign soft_start  = wr_ctrl && !soft_rst_q && mgmt_i.wdata[pbc_pkg::BIT_SOFT_RESET];
  assign strap_ready = (strap_fill_q == 2'h3) && (strap_s2_q == strap_s3_q);

  // strap synchroniser; the first stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      strap_s1_q <= 1'b0;
      strap_s2_q <= 1'b0;
      strap_s3_q <= 1'b0;
    end else begin
      strap_s1_q <= strap_isolate_i;
      strap_s2_q <= strap_s1_q;
      strap_s3_q <= strap_s2_q;
    end
  end

  // the stages are cleared by reset and agree while still empty, so the
  // compare waits until all three hold real pin samples
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      strap_fill_q <= 2'h0;
    end else if (strap_fill_q != 2'h3) begin
      strap_fill_q <= strap_fill_q + 2'h1;
    end
  end

  // strap caught once after hard reset and kept; a later pin change is ignored
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      strap_seen_q <= 1'b0;
      strap_val_q  <= 1'b1;
    end else if (!strap_seen_q && strap_ready) begin
      strap_seen_q <= 1'b1;
      strap_val_q  <= strap_s3_q;
    end
  end

  // isolate stays set until the strap is known, so no pin drives too early
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      isolate_q <= 1'b1;
    end else if (!strap_seen_q) begin
      if (strap_ready) begin
        isolate_q <= strap_s3_q;
      end
    end else if (soft_start || soft_rst_q) begin
      isolate_q <= strap_val_q;
    end else if (wr_ctrl) begin
      isolate_q <= mgmt_i.wdata[pbc_pkg::BIT_ISOLATE];
    end
  end

  // read/write control fields, defaults restored by soft reset
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || soft_start || soft_rst_q) begin
      loopback_q  <= pbc_pkg::RST_LOOPBACK;
      link_ctrl_q <= pbc_pkg::RST_LINK_CTRL;
      col_test_q  <= pbc_pkg::RST_COL_TEST;
    end else if (wr_ctrl) begin
      loopback_q  <= mgmt_i.wdata[pbc_pkg::BIT_LOOPBACK];
      link_ctrl_q <= mgmt_i.wdata[pbc_pkg::BIT_LINK_CTRL];
      col_test_q  <= mgmt_i.wdata[pbc_pkg::BIT_COL_TEST];
    end
  end

  // link reset: self-clearing after the hold count runs out
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || soft_start || soft_rst_q) begin
      link_rst_q <= 1'b0;
      link_cnt_q <= 4'h0;
    end else if (wr_ctrl && mgmt_i.wdata[pbc_pkg::BIT_LINK_RESET]) begin
      link_rst_q <= 1'b1;
      link_cnt_q <= pbc_pkg::RESET_CYCLES - 4'h1;
    end else if (link_rst_q) begin
      if (link_cnt_q == 4'h0) begin
        link_rst_q <= 1'b0;
      end else begin
        link_cnt_q <= link_cnt_q - 4'h1;
      end
    end
  end

  // soft reset: self-clearing, a new write during it is ignored
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      soft_rst_q <= 1'b0;
      soft_cnt_q <= 4'h0;
    end else if (soft_rst_q) begin
      if (soft_done) begin
        soft_rst_q <= 1'b0;
      end else begin
        soft_cnt_q <= soft_cnt_q - 4'h1;
      end
    end else if (soft_start) begin
      soft_rst_q <= 1'b1;
      soft_cnt_q <= pbc_pkg::RESET_CYCLES - 4'h1;
    end
  end

  // only writable and self-clearing fields may ever read back as one
  localparam logic [15:0] READ_MASK = (16'h0001 << pbc_pkg::BIT_SOFT_RESET)
                                    | (16'h0001 << pbc_pkg::BIT_LOOPBACK)
                                    | (16'h0001 << pbc_pkg::BIT_LINK_CTRL)
                                    | (16'h0001 << pbc_pkg::BIT_ISOLATE)
                                    | (16'h0001 << pbc_pkg::BIT_LINK_RESET)
                                    | (16'h0001 << pbc_pkg::BIT_COL_TEST);

  // read data gathered from the field registers
  always_comb begin
    live_bits = 16'h0000;
    live_bits[pbc_pkg::BIT_SOFT_RESET] = soft_rst_q;
    live_bits[pbc_pkg::BIT_LOOPBACK]   = loopback_q;
    live_bits[pbc_pkg::BIT_LINK_CTRL]  = link_ctrl_q;
    live_bits[pbc_pkg::BIT_ISOLATE]    = isolate_q;
    live_bits[pbc_pkg::BIT_LINK_RESET] = link_rst_q;
    live_bits[pbc_pkg::BIT_COL_TEST]   = col_test_q;
  end

  // fixed fields are masked to zero bit by bit, whatever the registers hold
  for (genvar b = 0; b < 16; b++) begin : g_rd
    assign rd_bits[b] = live_bits[b] & READ_MASK[b];
  end

  assign mgmt_rdata_o = rd_bits;

  assign phy_reset_o  = link_rst_q || soft_rst_q;
  assign soft_reset_o = soft_rst_q;

  // datapath: loopback, collision test and enable gating
  logic active;
  assign active = link_ctrl_q && !phy_reset_o;

  // line side: only normal operation reaches the wire
  always_comb begin
    line_tx_o = '0;
    if (active && !loopback_q && !col_test_q) begin
      line_tx_o = mac_tx_i;
    end
  end

  // mac side: loopback wins over collision test, so both set gives loopback
  always_comb begin
    mac_rx_o = '0;
    if (active) begin
      if (loopback_q) begin
        mac_rx_o.crs  = mac_tx_i.txen;
        mac_rx_o.rxdv = mac_tx_i.txen;
        mac_rx_o.rxer = mac_tx_i.txer;
        mac_rx_o.rxd  = mac_tx_i.txd;
      end else if (col_test_q) begin
        mac_rx_o.col = mac_tx_i.txen;
      end else begin
        mac_rx_o = line_rx_i;
      end
    end
  end

  // enables are active low
  assign mac_rx_oe_n_o = isolate_q;
  assign line_oe_n_o   = isolate_q || loopback_q || col_test_q || !active;

endmodule : pbc_control
`default_nettype wire

//--- src/pbc_pkg.sv
package pbc_pkg;

  localparam logic [4:0]  CTRL_ADDR       = 5'h00;

  localparam int          BIT_SOFT_RESET  = 15;
  localparam int          BIT_LOOPBACK    = 14;
  localparam int          BIT_SPEED_LSB   = 13;
  localparam int          BIT_LINK_CTRL   = 12;
  localparam int          BIT_LOW_POWER   = 11;
  localparam int          BIT_ISOLATE     = 10;
  localparam int          BIT_LINK_RESET  = 9;
  localparam int          BIT_DUPLEX      = 8;
  localparam int          BIT_COL_TEST    = 7;
  localparam int          BIT_SPEED_MSB   = 6;
  localparam int          BIT_UNIDIR      = 5;

  localparam logic        RST_LOOPBACK    = 1'b0;
  localparam logic        RST_LINK_CTRL   = 1'b0;
  localparam logic        RST_COL_TEST    = 1'b0;

  // cycles that a link or soft reset holds its internal pulse
  localparam int          RESET_NS        = 400;
  localparam int          CLK_NS          = 50;
  localparam logic [3:0]  RESET_CYCLES    = 4'((RESET_NS + CLK_NS - 1) / CLK_NS);

  typedef struct packed {
    logic       req;
    logic       wr;
    logic [4:0] addr;
    logic [15:0] wdata;
  } pbc_mgmt_req_t;

  typedef struct packed {
    logic       txen;
    logic       txer;
    logic [3:0] txd;
  } pbc_mii_tx_t;

  typedef struct packed {
    logic       crs;
    logic       col;
    logic       rxdv;
    logic       rxer;
    logic [3:0] rxd;
  } pbc_mii_rx_t;

endpackage : pbc_pkg

//--- verification/pbc_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module pbc_assertions (
  input wire logic                   clk_i,
  input wire logic                   reset_n_i,
  input wire pbc_pkg::pbc_mgmt_req_t mgmt_i,
  input wire logic [15:0]            mgmt_rdata_o,
  input wire pbc_pkg::pbc_mii_tx_t   mac_tx_i,
  input wire pbc_pkg::pbc_mii_rx_t   mac_rx_o,
  input wire logic                   line_oe_n_o,
  input wire logic                   mac_rx_oe_n_o,
  input wire logic                   phy_reset_o,
  input wire logic                   soft_reset_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic [15:0] r;
  logic        w;
  assign r = mgmt_rdata_o;
  // writes landing during a soft reset are dropped, so leave them out
  assign w = mgmt_i.req && mgmt_i.wr && mgmt_i.addr == pbc_pkg::CTRL_ADDR && !soft_reset_o
             && !mgmt_i.wdata[15];
  a_iso_pins: assert property (r[10] |-> mac_rx_oe_n_o && line_oe_n_o) else $error("iso");
  a_duplex_zero: assert property (!r[8]) else $error("duplex");
  a_speed_zero: assert property (!r[13] && !r[6]) else $error("speed");
  a_unused_zero: assert property (r[5:0] == 6'h00) else $error("unused");
  a_lrst_start: assert property (w && mgmt_i.wdata[9] |=> r[9] && phy_reset_o)
    else $error("lrst");
  a_lrst_clears: assert property ($rose(r[9]) |-> ##[1:8] !r[9]) else $error("lrst sc");
  a_soft_defaults: assert property ($rose(soft_reset_o) |-> r[14:11] == 4'h0 && r[9:7] == 3'h0
    ##[1:8] !soft_reset_o) else $error("soft");
  a_col_follow: assert property (r[7] && r[12] && !r[14] && !r[10] && !phy_reset_o
    |-> mac_rx_o.col == mac_tx_i.txen) else $error("col");
  c_lrst: cover property (w && mgmt_i.wdata[9]);
  c_soft: cover property ($rose(soft_reset_o));
  c_col: cover property (r[7] && mac_rx_o.col);
endmodule : pbc_assertions
`default_nettype wire

//--- verification/pbc_mgmt_model.sv
`timescale 1ns/1ps
`default_nettype none
module pbc_mgmt_model (
  input  wire logic                  clk_i,
  input  wire logic [15:0]           rdata_i,
  output var pbc_pkg::pbc_mgmt_req_t mgmt_o
);
  initial mgmt_o = '0;
  // one idle cycle after each access, so req is never driven twice in a time step
  task automatic acc(input logic w, input logic [15:0] d, output logic [15:0] q);
    mgmt_o <= '{1'b1, w, pbc_pkg::CTRL_ADDR, d};
    #1 q = rdata_i;
    @(posedge clk_i);
    #1 mgmt_o <= '0;
    @(posedge clk_i);
    #1;
  endtask : acc
endmodule : pbc_mgmt_model
`default_nettype wire

//--- verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                   clk_i = 1'b0;
  logic                   reset_n_i = 1'b0;
  logic                   strap_isolate_i = 1'b1;
  logic                   mac_rx_oe_n_o, line_oe_n_o, phy_reset_o, soft_reset_o;
  logic [15:0]            mgmt_rdata_o, q;
  pbc_pkg::pbc_mgmt_req_t mgmt_i;
  pbc_pkg::pbc_mii_tx_t   mac_tx_i = '{1'b1, 1'b0, 4'ha}, line_tx_o;
  pbc_pkg::pbc_mii_rx_t   line_rx_i = '0, mac_rx_o;
  int                     n_mismatch = 0;
  int                     checked = 0;
  always #25 clk_i = ~clk_i;
  pbc_control dut (.clk_i, .reset_n_i, .strap_isolate_i, .mgmt_i, .mgmt_rdata_o, .mac_tx_i,
    .line_rx_i, .mac_rx_o, .mac_rx_oe_n_o, .line_tx_o, .line_oe_n_o, .phy_reset_o,
    .soft_reset_o);
  pbc_mgmt_model m (.clk_i, .rdata_i(mgmt_rdata_o), .mgmt_o(mgmt_i));
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic rdc(input int n, input logic [15:0] e);
    repeat (n) @(posedge clk_i);
    #1 m.acc(1'b0, 16'h0000, q);
    chk("ctrl", e, q);
  endtask : rdc
  task final_report;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report
  initial begin
    repeat (3) @(posedge clk_i);
    #1 reset_n_i = 1'b1;
    rdc(6, 16'h0400);
    chk("iso", 16'h0001, {15'h0, mac_rx_oe_n_o & line_oe_n_o});
    m.acc(1'b1, 16'h7fff, q);
    rdc(1, 16'h5680);
    rdc(8, 16'h5480);
    m.acc(1'b1, 16'h1080, q);
    chk("col", 16'h0001, {15'h0, mac_rx_o.col});
    m.acc(1'b1, 16'h5000, q);
    chk("loop", 16'h001a, {11'h0, line_oe_n_o, mac_rx_o.rxd});
    m.acc(1'b1, 16'h1000, q);
    chk("line", 16'h002a, {9'h0, line_oe_n_o, line_tx_o});
    m.acc(1'b1, 16'h8000, q);
    rdc(1, 16'h8400);
    rdc(8, 16'h0400);
    final_report;
  end
  // the sequence needs about 50 cycles; this leaves ample slack
  initial begin
    #20us;
    n_mismatch++;
    final_report;
  end
endmodule : tb_top
bind pbc_control pbc_assertions u_chk (.clk_i, .reset_n_i, .mgmt_i, .mgmt_rdata_o, .mac_tx_i,
  .mac_rx_o, .line_oe_n_o, .mac_rx_oe_n_o, .phy_reset_o, .soft_reset_o);
`default_nettype wire
